// ### verilog/dbc_consts.svh
// offsets, field positions, reset values and timing counts of the converter control registers
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

`define DBC_OFS_C0_MODE      8'h02
`define DBC_OFS_C0_LIMSLEW   8'h03
`define DBC_OFS_C1_MODE      8'h04
`define DBC_OFS_C1_LIMSLEW   8'h05
`define DBC_OFS_C0_VCODE     8'h06
`define DBC_OFS_C1_VCODE     8'h07

`define DBC_BIT_FORCED_PWM   3
`define DBC_BIT_DISCHARGE    2
`define DBC_BIT_PIN_GATING   1
`define DBC_BIT_SW_ENABLE    0
`define DBC_ILIM_HI          5
`define DBC_ILIM_LO          3
`define DBC_SLEW_HI          2
`define DBC_SLEW_LO          0

`define DBC_RST_MODE         8'h07
`define DBC_RST_C0_LIMSLEW   8'h1A
`define DBC_RST_C1_LIMSLEW   8'h1B
`define DBC_RST_C0_VCODE     8'hB1
`define DBC_RST_C1_VCODE     8'h93

`define DBC_VCODE_RSV_MAX    8'h13
`define DBC_VCODE_SEG1_MAX   8'h17
`define DBC_VCODE_SEG2_MAX   8'h9D
`define DBC_SLEW_RSV_MAX     3'h1
`define DBC_ILIM_MAX         3'h3

`define DBC_SLEW_TICK_NS     1000
`define DBC_CLK_NS           8
`define DBC_SLEW_TICK_CYC    (`DBC_SLEW_TICK_NS / `DBC_CLK_NS)

`endif

// ### verilog/dbc_pkg.sv
// types shared by the converter control register bank
package dbc_pkg;
    typedef logic [7:0] dbc_byte_t;
    typedef logic [15:0] dbc_uv_t;
endpackage

// ### verilog/dbc_ramp.sv
// voltage ramp generator for one converter: steps the applied target toward the code set point
`timescale 1ns/1ps
`default_nettype none
`include "dbc_consts.svh"

module dbc_ramp
(
    input  wire logic           clk_sys,
    input  wire logic           resetn,
    input  wire logic           tick,
    input  wire logic [2:0]     ramp_rate,
    input  wire logic [7:0]     target_code,
    input  wire logic [7:0]     reset_code,
    output logic      [7:0]     applied_code,
    output logic                ramping
);

    // dividing ratio between ramp steps, slower codes step less often; code 7 needs 32, so six bits
    function automatic logic [5:0] dbc_rate_div(input logic [2:0] r);
        dbc_rate_div = (r <= `DBC_SLEW_RSV_MAX) ? 6'h01 : 6'(6'h01 << 3'(r - 3'h2));
    endfunction

    logic [7:0] code_reg;
    logic [7:0] code_next;
    logic [5:0] div_reg;
    logic [5:0] div_next;
    logic       init_reg;
    logic       init_next;

    // one code step per divided tick, up or down at the same rate
    always_comb
    begin
        code_next = code_reg;
        div_next  = div_reg;
        init_next = 1'b1;
        if (!init_reg)
        begin
            code_next = reset_code;
            div_next  = 6'h00;
        end
        else if (tick)
        begin
            if (div_reg + 6'h01 >= dbc_rate_div(ramp_rate))
            begin
                div_next = 6'h00;
                if (code_reg < target_code)
                    code_next = code_reg + 8'h01; // rising
                else if (code_reg > target_code)
                    code_next = code_reg - 8'h01; // falling
            end
            else
                div_next = div_reg + 6'h01;
        end
    end

    // state registers
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            code_reg <= 8'h00;
            div_reg  <= 6'h00;
            init_reg <= 1'b0;
        end
        else
        begin
            code_reg <= code_next;
            div_reg  <= div_next;
            init_reg <= init_next;
        end
    end

    assign applied_code = code_reg;
    assign ramping      = init_reg && (code_reg != target_code);

    // a step that is taken must be one code toward the target
    property p_ramp_dir;
        @(posedge clk_sys) disable iff (!resetn)
        (init_reg && $past(init_reg) && $changed(code_reg)) |->
            (($past(code_reg) < $past(target_code)) ? (code_reg == $past(code_reg) + 8'h01)
                                                     : (code_reg == $past(code_reg) - 8'h01));
    endproperty
    a_ramp_dir: assert property (p_ramp_dir) else $error("ramp step not one code");

endmodule
`default_nettype wire

// ### verilog/dbc_regs.sv
// register bank and control decode for two step-down converters
`timescale 1ns/1ps
`default_nettype none
`include "dbc_consts.svh"

// Function
// - mode bit3: auto PFM/PWM or forced PWM
// - bit2 connects discharge resistor while disabled
// - bit1 set: enable needs pin too
// - bit0 software enable, resets set
// - current limit bits5:3, reset code three
// - current limit writes apply while running
// - slew field bits2:0, per-converter reset
// - slew governs rising and falling ramps
// - eight-bit voltage code, low codes reserved
// - codes 0x14-0x17: 0.7V, 10mV steps
// - codes 0x18-0x9D: 0.735V, 5mV steps
// - codes 0x9E-0xFF: 1.42V, 20mV steps
module dbc_regs
(
    input  wire logic           clk_sys,
    input  wire logic           resetn,
    input  wire logic [7:0]     reg_addr,
    input  wire logic           reg_wr,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    output logic                reg_hit,
    input  wire logic           en_pin,
    output logic      [1:0]     conv_forced_pwm,
    output logic      [1:0]     conv_discharge_on,
    output logic      [1:0]     conv_run,
    output logic      [5:0]     conv_current_limit,
    output logic      [5:0]     conv_ramp_rate,
    output logic      [15:0]    conv_applied_code,
    output logic      [31:0]    conv_target_uv,
    output logic      [1:0]     conv_ramping,
    output logic      [1:0]     conv_code_reserved
);

    // code to 100 uV units, three linear segments; reserved codes give zero
    function automatic dbc_pkg::dbc_uv_t dbc_code_uv(input logic [7:0] c);
        if (c <= `DBC_VCODE_RSV_MAX)
            dbc_code_uv = 16'h0000;
        else if (c <= `DBC_VCODE_SEG1_MAX)
            dbc_code_uv = 16'(32'd700000 / 32'd100 + (32'(c) - 32'h14) * 32'd100);
        else if (c <= `DBC_VCODE_SEG2_MAX)
            dbc_code_uv = 16'(32'd7350 + (32'(c) - 32'h18) * 32'd50);
        else
            dbc_code_uv = 16'(32'd14200 + (32'(c) - 32'h9E) * 32'd200);
    endfunction

    logic [7:0] mode0_reg, mode0_next;
    logic [7:0] mode1_reg, mode1_next;
    logic [7:0] ls0_reg,   ls0_next;
    logic [7:0] ls1_reg,   ls1_next;
    logic [7:0] vc0_reg,   vc0_next;
    logic [7:0] vc1_reg,   vc1_next;
    logic       pin_meta_reg;
    logic       pin_sync_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic       tick;
    logic [7:0] ramp_code0;
    logic [7:0] ramp_code1;

    ////////////////////////////////////////////////////////////////////////
    // register writes: whole byte stored, reserved bits included
    always_comb
    begin
        mode0_next = mode0_reg;
        mode1_next = mode1_reg;
        ls0_next   = ls0_reg;
        ls1_next   = ls1_reg;
        vc0_next   = vc0_reg;
        vc1_next   = vc1_reg;
        if (reg_wr)
        begin
            case (reg_addr)
                `DBC_OFS_C0_MODE:    mode0_next = reg_wdata;
                `DBC_OFS_C1_MODE:    mode1_next = reg_wdata;
                `DBC_OFS_C0_LIMSLEW: ls0_next   = reg_wdata; // accepted any time
                `DBC_OFS_C1_LIMSLEW: ls1_next   = reg_wdata; // accepted any time
                `DBC_OFS_C0_VCODE:   vc0_next   = reg_wdata;
                `DBC_OFS_C1_VCODE:   vc1_next   = reg_wdata;
                default:             ;
            endcase
        end
    end

    // read mux, registered; unmapped reads zero
    always_comb
    begin
        case (reg_addr)
            `DBC_OFS_C0_MODE:    rdata_next = mode0_reg;
            `DBC_OFS_C1_MODE:    rdata_next = mode1_reg;
            `DBC_OFS_C0_LIMSLEW: rdata_next = ls0_reg;
            `DBC_OFS_C1_LIMSLEW: rdata_next = ls1_reg;
            `DBC_OFS_C0_VCODE:   rdata_next = vc0_reg;
            `DBC_OFS_C1_VCODE:   rdata_next = vc1_reg;
            default:             rdata_next = 8'h00;
        endcase
    end

    assign reg_hit   = (reg_addr >= `DBC_OFS_C0_MODE) && (reg_addr <= `DBC_OFS_C1_VCODE);
    assign reg_rdata = rdata_reg;

    // register state with documented defaults
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mode0_reg <= `DBC_RST_MODE;
            mode1_reg <= `DBC_RST_MODE;
            ls0_reg   <= `DBC_RST_C0_LIMSLEW;
            ls1_reg   <= `DBC_RST_C1_LIMSLEW;
            vc0_reg   <= `DBC_RST_C0_VCODE;
            vc1_reg   <= `DBC_RST_C1_VCODE;
            rdata_reg <= 8'h00;
        end
        else
        begin
            mode0_reg <= mode0_next;
            mode1_reg <= mode1_next;
            ls0_reg   <= ls0_next;
            ls1_reg   <= ls1_next;
            vc0_reg   <= vc0_next;
            vc1_reg   <= vc1_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable pin synchroniser
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= en_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // microsecond tick for the ramp generators
    logic [7:0] tdiv_reg, tdiv_next;
    always_comb
    begin
        tdiv_next = (tdiv_reg == 8'(`DBC_SLEW_TICK_CYC - 1)) ? 8'h00 : tdiv_reg + 8'h01;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            tdiv_reg <= 8'h00;
        else
            tdiv_reg <= tdiv_next;
    end
    assign tick = (tdiv_reg == 8'(`DBC_SLEW_TICK_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // control decode to the analogue side; bits 7:4 / 7:6 drive nothing
    assign conv_forced_pwm    = {mode1_reg[`DBC_BIT_FORCED_PWM], mode0_reg[`DBC_BIT_FORCED_PWM]};
    assign conv_run[0] = mode0_reg[`DBC_BIT_SW_ENABLE] &&
                         (!mode0_reg[`DBC_BIT_PIN_GATING] || pin_sync_reg);
    assign conv_run[1] = mode1_reg[`DBC_BIT_SW_ENABLE] &&
                         (!mode1_reg[`DBC_BIT_PIN_GATING] || pin_sync_reg);
    assign conv_discharge_on  = {mode1_reg[`DBC_BIT_DISCHARGE] && !conv_run[1],
                                 mode0_reg[`DBC_BIT_DISCHARGE] && !conv_run[0]};
    assign conv_current_limit = {ls1_reg[`DBC_ILIM_HI:`DBC_ILIM_LO],
                                 ls0_reg[`DBC_ILIM_HI:`DBC_ILIM_LO]}; // live, no disable needed
    assign conv_ramp_rate     = {ls1_reg[`DBC_SLEW_HI:`DBC_SLEW_LO],
                                 ls0_reg[`DBC_SLEW_HI:`DBC_SLEW_LO]};
    assign conv_code_reserved = {vc1_reg <= `DBC_VCODE_RSV_MAX, vc0_reg <= `DBC_VCODE_RSV_MAX};
    assign conv_target_uv     = {dbc_code_uv(ramp_code1), dbc_code_uv(ramp_code0)};
    assign conv_applied_code  = {ramp_code1, ramp_code0};

    // ramp generators, one per converter
    dbc_ramp u_ramp0
    (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .tick         (tick),
        .ramp_rate    (ls0_reg[`DBC_SLEW_HI:`DBC_SLEW_LO]),
        .target_code  (vc0_reg),
        .reset_code   (`DBC_RST_C0_VCODE),
        .applied_code (ramp_code0),
        .ramping      (conv_ramping[0])
    );

    dbc_ramp u_ramp1
    (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .tick         (tick),
        .ramp_rate    (ls1_reg[`DBC_SLEW_HI:`DBC_SLEW_LO]),
        .target_code  (vc1_reg),
        .reset_code   (`DBC_RST_C1_VCODE),
        .applied_code (ramp_code1),
        .ramping      (conv_ramping[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_mode_default;
        @(posedge clk_sys) $rose(resetn) |-> mode0_reg == 8'h07 && mode1_reg == 8'h07;
    endproperty
    a_mode_default: assert property (p_mode_default) else $error("mode default wrong");

    property p_fpwm;
        @(posedge clk_sys) disable iff (!resetn)
        conv_forced_pwm[0] == mode0_reg[3] && conv_forced_pwm[1] == mode1_reg[3];
    endproperty
    a_fpwm: assert property (p_fpwm) else $error("forced pwm mismatch");

    property p_discharge;
        @(posedge clk_sys) disable iff (!resetn)
        conv_discharge_on[0] |-> !conv_run[0] && mode0_reg[2];
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge while running");

    property p_gating;
        @(posedge clk_sys) disable iff (!resetn)
        (mode0_reg[1] && !pin_sync_reg) |-> !conv_run[0];
    endproperty
    a_gating: assert property (p_gating) else $error("gated converter running");

    property p_ungated;
        @(posedge clk_sys) disable iff (!resetn)
        !mode1_reg[1] |-> conv_run[1] == mode1_reg[0];
    endproperty
    a_ungated: assert property (p_ungated) else $error("ungated enable mismatch");

    property p_ilim_live;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == 8'h03 && conv_run[0]) |=> conv_current_limit[2:0] == $past(reg_wdata[5:3]);
    endproperty
    a_ilim_live: assert property (p_ilim_live) else $error("limit not applied");

    property p_slew_default;
        @(posedge clk_sys) $rose(resetn) |-> conv_ramp_rate == 6'h1A && conv_current_limit == 6'h1B;
    endproperty
    a_slew_default: assert property (p_slew_default) else $error("limit/slew default wrong");

    property p_vcode_default;
        @(posedge clk_sys) $rose(resetn) |-> vc0_reg == 8'hB1;
    endproperty
    a_vcode_default: assert property (p_vcode_default) else $error("voltage default wrong");

    property p_rsv_store;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == 8'h02) |=> mode0_reg == $past(reg_wdata);
    endproperty
    a_rsv_store: assert property (p_rsv_store) else $error("byte not stored");

    property p_uv_seg;
        @(posedge clk_sys) disable iff (!resetn)
        ramp_code0 == 8'h9D |-> conv_target_uv[15:0] == 16'd14000;
    endproperty
    a_uv_seg: assert property (p_uv_seg) else $error("5mV segment end wrong");

    property p_uv_low;
        @(posedge clk_sys) disable iff (!resetn)
        ramp_code0 == 8'h14 |-> conv_target_uv[15:0] == 16'd7000;
    endproperty
    a_uv_low: assert property (p_uv_low) else $error("lowest code voltage wrong");

    property p_uv_seg3;
        @(posedge clk_sys) disable iff (!resetn)
        ramp_code0 == 8'h9E |-> conv_target_uv[15:0] == 16'd14200;
    endproperty
    a_uv_seg3: assert property (p_uv_seg3) else $error("20mV segment start wrong");

    property p_uv_top;
        @(posedge clk_sys) disable iff (!resetn)
        ramp_code0 == 8'hFF |-> conv_target_uv[15:0] == 16'd33600;
    endproperty
    a_uv_top: assert property (p_uv_top) else $error("top code voltage wrong");

    property p_discharge_idle;
        @(posedge clk_sys) disable iff (!resetn)
        (mode0_reg[2] && !conv_run[0]) |-> conv_discharge_on[0];
    endproperty
    a_discharge_idle: assert property (p_discharge_idle) else $error("discharge missing while off");

    property p_gating1;
        @(posedge clk_sys) disable iff (!resetn)
        (mode1_reg[1] && !pin_sync_reg) |-> !conv_run[1];
    endproperty
    a_gating1: assert property (p_gating1) else $error("gated converter 1 running");

    property p_ilim_live1;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == 8'h05 && conv_run[1]) |=> conv_current_limit[5:3] == $past(reg_wdata[5:3]);
    endproperty
    a_ilim_live1: assert property (p_ilim_live1) else $error("limit 1 not applied");

    property p_rdata_vcode;
        @(posedge clk_sys) disable iff (!resetn)
        reg_addr == `DBC_OFS_C0_VCODE |=> reg_rdata == $past(vc0_reg);
    endproperty
    a_rdata_vcode: assert property (p_rdata_vcode) else $error("voltage code read wrong");

endmodule
`default_nettype wire

// ### verification/dbc_regs_tb.sv
// self-checking testbench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct { int sel; string name; logic [31:0] exp; } dbc_note_t;

    logic        clk_sys;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_hit;
    logic        en_pin;
    logic [1:0]  conv_forced_pwm;
    logic [1:0]  conv_discharge_on;
    logic [1:0]  conv_run;
    logic [5:0]  conv_current_limit;
    logic [5:0]  conv_ramp_rate;
    logic [15:0] conv_applied_code;
    logic [31:0] conv_target_uv;
    logic [1:0]  conv_ramping;
    logic [1:0]  conv_code_reserved;
    int          errors;
    int          checked;
    int          i;
    int          k;
    int          ramp_n;
    logic [31:0] rng;
    logic [31:0] seen;
    logic [7:0]  sh [2:7];
    logic [7:0]  rst_val [2:7];
    logic [7:0]  codes [7];
    logic [3:0]  m0;
    logic [3:0]  m1;
    logic        r0;
    logic        r1;
    dbc_note_t   notes [$];
    dbc_note_t   nt;

    dbc_regs uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .en_pin(en_pin),
        .conv_forced_pwm(conv_forced_pwm), .conv_discharge_on(conv_discharge_on), .conv_run(conv_run),
        .conv_current_limit(conv_current_limit), .conv_ramp_rate(conv_ramp_rate),
        .conv_applied_code(conv_applied_code), .conv_target_uv(conv_target_uv),
        .conv_ramping(conv_ramping), .conv_code_reserved(conv_code_reserved));

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 8 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // voltage in 100 uV units from an output code
    function automatic logic [31:0] uv(input logic [7:0] c);
        if (c <= 8'h13) return 32'h0;
        if (c <= 8'h17) return 32'h1B58 + 32'(c - 8'h14) * 32'h64;
        if (c <= 8'h9D) return 32'h1CB6 + 32'(c - 8'h18) * 32'h32;
        return 32'h3778 + 32'(c - 8'h9E) * 32'hC8;
    endfunction

    function automatic logic [31:0] obs(input int s);
        case (s)
            0: return {24'h0, reg_rdata};
            1: return {30'h0, conv_forced_pwm};
            2: return {30'h0, conv_discharge_on};
            3: return {30'h0, conv_run};
            4: return {26'h0, conv_current_limit};
            5: return {26'h0, conv_ramp_rate};
            6: return {24'h0, conv_applied_code[7:0]};
            7: return {16'h0, conv_target_uv[15:0]};
            8: return {31'h0, conv_ramping[0]};
            9: return {30'h0, conv_code_reserved};
            11: return {24'h0, conv_applied_code[15:8]};
            12: return {16'h0, conv_target_uv[31:16]};
            13: return {31'h0, conv_ramping[1]};
            // four steps at 32 ticks of 125 cycles each, first step anywhere in one divider period
            14: return {31'h0, ramp_n >= 11800 && ramp_n <= 16300};
            default: return {31'h0, reg_hit};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks: the driver notes each expectation, the monitor compares
    task automatic chk(input int s, input string nm, input logic [31:0] e);
        notes.push_back('{s, nm, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
    endtask

    task automatic done;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge clk_sys);
        chk(0, "rdata", {24'h0, e});
        chk(10, "hit", {31'h0, (a >= 8'h02 && a <= 8'h07)});
    endtask

    task automatic wait_ramp(input int c);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (conv_ramping[c] !== 1'b0 && n < 40000)
        begin
            @(negedge clk_sys);
            n++;
        end
        ramp_n = n;
        if (n >= 40000)
        begin
            errors++;
            $display("CHECK FAILED ramp_done expected 0 seen 1");
            conclude();
        end
    endtask

    task automatic conclude;
        repeat (2) @(negedge clk_sys);
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: takes every pending note, oldest first, as the outputs settle
    always @(negedge clk_sys)
    begin
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            seen = obs(nt.sel);
            checked++;
            if (seen !== nt.exp)
            begin
                errors++;
                $display("CHECK FAILED %s expected %h seen %h", nt.name, nt.exp, seen);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        errors = 0;
        checked = 0;
        rng = 32'h380935E0;
        rst_val = '{8'h07, 8'h1A, 8'h07, 8'h1B, 8'hB1, 8'h93};
        codes = '{8'hB1, 8'h9E, 8'h9D, 8'h18, 8'h17, 8'h14, 8'hFF};
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        en_pin = 1'b0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        // reset values and an unmapped read
        for (i = 2; i <= 7; i++)
            rd(8'(i), rst_val[i]);
        rd(8'h00, 8'h00);
        $display("test reset_values done");
        // random bytes, reserved bits included, then unmapped writes
        for (i = 2; i <= 7; i++)
        begin
            rng = xs(rng);
            sh[i] = rng[7:0];
            if (i >= 6 && sh[i] <= 8'h13)
                sh[i] = sh[i] + 8'h20; // keep clear of reserved output codes
            wr(8'(i), sh[i]);
        end
        wr(8'h01, 8'hFF);
        wr(8'h08, 8'hFF);
        for (i = 2; i <= 7; i++)
            rd(8'(i), sh[i]);
        rd(8'h08, 8'h00);
        for (i = 2; i <= 7; i++)
            wr(8'(i), rst_val[i]);
        done;
        $display("test readback done");
        // mode, discharge and enable decode against the pin
        for (k = 0; k < 2; k++)
        begin
            @(posedge clk_sys);
            en_pin <= k[0];
            repeat (3) @(posedge clk_sys);
            for (i = 0; i < 16; i++)
            begin
                rng = xs(rng);
                m0 = 4'(i);
                m1 = 4'(i) ^ rng[3:0];
                wr(8'h02, {rng[7:4], m0});
                wr(8'h04, {rng[11:8], m1});
                done;
                r0 = m0[0] && (!m0[1] || k[0]);
                r1 = m1[0] && (!m1[1] || k[0]);
                chk(1, "forced_pwm", {30'h0, m1[3], m0[3]});
                chk(2, "discharge", {30'h0, m1[2] && !r1, m0[2] && !r0});
                chk(3, "run", {30'h0, r1, r0});
            end
        end
        $display("test mode_decode done");
        // current limit and slew codes rewritten while running
        wr(8'h02, 8'h01);
        wr(8'h04, 8'h01);
        for (i = 0; i < 8; i++)
        begin
            wr(8'h03, {2'b11, 3'(i), 3'(7 - i)});
            wr(8'h05, {2'b00, 3'(7 - i), 3'(i)});
            done;
            chk(4, "current_limit", {26'h0, 3'(7 - i), 3'(i)});
            chk(5, "ramp_rate", {26'h0, 3'(i), 3'(7 - i)});
            chk(3, "run", 32'h3);
        end
        $display("test limit_slew done");
        // voltage codes at segment edges, falling then rising
        wr(8'h03, 8'h1A);
        for (i = 0; i < 7; i++)
        begin
            wr(8'h06, codes[i]);
            done;
            if (i > 0)
                chk(8, "ramping", 32'h1);
            wait_ramp(0);
            chk(6, "applied_code", {24'h0, codes[i]});
            chk(7, "target_uv", uv(codes[i]));
            @(posedge clk_sys);
        end
        // slowest ramp code on converter 1: four codes at one step per 32 ticks
        chk(11, "applied_code1", 32'h93);
        wr(8'h05, 8'h1F);
        wr(8'h07, 8'h97);
        done;
        chk(13, "ramping1", 32'h1);
        wait_ramp(1);
        chk(14, "ramp_cycles", 32'h1);
        chk(11, "applied_code1", 32'h97);
        chk(12, "target_uv1", uv(8'h97));
        @(posedge clk_sys);
        $display("test slow_ramp done");
        wr(8'h07, 8'h13);
        done;
        chk(9, "code_reserved", 32'h2);
        wr(8'h07, 8'h14);
        done;
        chk(9, "code_reserved", 32'h0);
        $display("test voltage_codes done");
        @(posedge clk_sys);
        conclude();
    end
endmodule

`default_nettype wire
